// *** inc/tkr_pkg.sv ***
/*
  Package for the timekeeping memory port: clock slot layout, field masks,
  calendar reset values, timing figures and the host bus carrier.
  Assumes a single 100 MHz system clock and a host bus sampled on it.
*/
package tkr_pkg;

  // Memory geometry
  localparam int unsigned ADDR_W     = 19;            // Byte address width
  localparam int unsigned DATA_W     = 8;             // Byte lane
  localparam int unsigned MEM_DEPTH  = 524288;        // Bytes of storage
  localparam int unsigned SLOT_COUNT = 8;             // Clock bytes at the top

  // Clock register offsets
  localparam logic [18:0] OFS_CENTURY = 19'h7fff8;    // century_control
  localparam logic [18:0] OFS_SECONDS = 19'h7fff9;    // seconds_and_stop
  localparam logic [18:0] OFS_MINUTES = 19'h7fffa;    // minutes_count
  localparam logic [18:0] OFS_HOURS   = 19'h7fffb;    // hours_count
  localparam logic [18:0] OFS_WEEKDAY = 19'h7fffc;    // weekday_and_flags
  localparam logic [18:0] OFS_DATE    = 19'h7fffd;    // day_of_month
  localparam logic [18:0] OFS_MONTH   = 19'h7fffe;    // month_count
  localparam logic [18:0] OFS_YEAR    = 19'h7ffff;    // year_count

  // Slot indices, low three address bits of each offset
  localparam logic [2:0] SLOT_CENT = OFS_CENTURY[2:0];
  localparam logic [2:0] SLOT_SEC  = OFS_SECONDS[2:0];
  localparam logic [2:0] SLOT_MIN  = OFS_MINUTES[2:0];
  localparam logic [2:0] SLOT_HOUR = OFS_HOURS[2:0];
  localparam logic [2:0] SLOT_WDAY = OFS_WEEKDAY[2:0];
  localparam logic [2:0] SLOT_DATE = OFS_DATE[2:0];
  localparam logic [2:0] SLOT_MON  = OFS_MONTH[2:0];
  localparam logic [2:0] SLOT_YEAR = OFS_YEAR[2:0];
  localparam logic [15:0] SLOT_BASE_HI = OFS_CENTURY[18:3];  // Clock area tag

  // Control bit positions
  localparam int unsigned BIT_WRITE  = 7;             // century_control write bit
  localparam int unsigned BIT_READ   = 6;             // century_control read bit
  localparam int unsigned BIT_STOP   = 7;             // stop_bit in seconds
  localparam int unsigned BIT_BATT   = 7;             // battery_good_flag in weekday
  localparam int unsigned BIT_FTEST  = 6;             // freq_test_bit in weekday

  // Time field masks per slot
  localparam logic [7:0] TM_CENT = 8'h3f;
  localparam logic [7:0] TM_SEC  = 8'h7f;
  localparam logic [7:0] TM_MIN  = 8'h7f;
  localparam logic [7:0] TM_HOUR = 8'h3f;
  localparam logic [7:0] TM_WDAY = 8'h07;
  localparam logic [7:0] TM_DATE = 8'h3f;
  localparam logic [7:0] TM_MON  = 8'h1f;
  localparam logic [7:0] TM_YEAR = 8'hff;
  // Control bit masks per slot
  localparam logic [7:0] CM_CENT = 8'hc0;
  localparam logic [7:0] CM_SEC  = 8'h80;
  localparam logic [7:0] CM_WDAY = 8'hc0;

  // BCD ranges
  localparam logic [7:0] MAX_SEC  = 8'h59;
  localparam logic [7:0] MAX_MIN  = 8'h59;
  localparam logic [7:0] MAX_HOUR = 8'h23;
  localparam logic [7:0] MAX_WDAY = 8'h07;
  localparam logic [7:0] MAX_MON  = 8'h12;
  localparam logic [7:0] MAX_YEAR = 8'h99;
  localparam logic [7:0] MAX_CENT = 8'h39;
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] BCD_ONE  = 8'h01;

  // Calendar reset values
  localparam logic [7:0] RST_CENT = 8'h20;
  localparam logic [7:0] RST_YEAR = 8'h00;
  localparam logic [7:0] RST_MON  = 8'h01;
  localparam logic [7:0] RST_DATE = 8'h01;
  localparam logic [7:0] RST_WDAY = 8'h01;
  localparam logic [7:0] RST_TIME = 8'h00;

  // Timing
  localparam int unsigned CLK_HZ        = 100000000;  // clk_sys rate
  localparam int unsigned TICK_HZ       = 1;          // Calendar update rate
  localparam int unsigned FTEST_HZ      = 512;        // Test square wave
  localparam int unsigned SEC_CYCLES    = CLK_HZ / TICK_HZ;
  localparam int unsigned FT_HALF_CYCLES = CLK_HZ / (2 * FTEST_HZ);

  // Host bus carrier, all active-low strobes
  typedef struct packed {
    logic              cs_n;   // Chip select
    logic              oe_n;   // Output drive enable
    logic              we_n;   // Write strobe
    logic [18:0]       addr;   // Byte address
    logic [7:0]        data;   // Data pins as seen from outside
  } tkr_bus_t;

  // Port sequencer states, Gray along idle-read-write-end
  typedef enum logic [1:0] {
    TKR_IDLE  = 2'b00,
    TKR_READ  = 2'b01,
    TKR_WRITE = 2'b11,
    TKR_END   = 2'b10
  } tkr_state_t;

endpackage : tkr_pkg

// *** src/tkr_port.sv ***
/*
  Timekeeping nonvolatile RAM port: byte-wide host port onto a 512k byte
  store whose top eight bytes overlay a BCD calendar clock.
  Assumes host strobes synchronous to clk_sys, and power monitor levels
  from an analog comparator already clean and synchronous.
*/
`timescale 1ns/10ps

// Behaviour
// R1: Unassigned clock-area bits act as plain storage
// R2: Read when select low, drive low, strobe high
// R3: Read data follows address without strobe edge
// R4: Data pins driven only with select and drive
// R5: Write while strobe and select both active
// R6: Host holds address, separates accesses
// R7: Write strobe releases read drive on data
// R8: Power fail blocks every read and write
// R9: Reset output asserted throughout power fail
// R10: On backup, calendar runs, storage kept
// R11: Reset output is open drain
// R12: Backup disabled until first good supply
// R13: Battery flag read-only, one means good
// R14: Read bit freezes view; clear reloads it
// R15: Write bit halts; clear loads counters
// R16: Stop bit halts oscillator and timekeeping
// R17: Frequency test toggles seconds bit at 512 Hz
// R18: Packed BCD fields roll over in range
module tkr_port #(
  parameter int unsigned SEC_CYCLES_P = tkr_pkg::SEC_CYCLES,     // Cycles per second
  parameter int unsigned FT_HALF_P    = tkr_pkg::FT_HALF_CYCLES  // Half period, test wave
) (
  input  wire logic             clk_sys,
  input  wire logic             reset_n,
  input  wire tkr_pkg::tkr_bus_t host_bus,
  input  wire logic             power_fail_level,
  input  wire logic             switchover_level,
  input  wire logic             battery_ok,
  output logic [7:0]            data_out,
  output logic                  data_oe_n,
  output logic                  rst_out,
  output logic                  rst_oe_n
);

  // BCD increment: returns {wrap, next}
  function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] last,
                                         input logic [7:0] first);
    logic [7:0] r;
    r = v;
    if (v >= last) begin
      return {1'b1, first};
    end
    if (v[3:0] == 4'h9) begin
      r = {4'(v[7:4] + 4'h1), 4'h0};
    end else begin
      r = {v[7:4], 4'(v[3:0] + 4'h1)};
    end
    return {1'b0, r};
  endfunction : bcd_inc

  // Last date of a month; leap every fourth year within the century
  function automatic logic [7:0] month_last(input logic [7:0] mon, input logic [7:0] yr);
    logic [5:0] mod_sum;
    mod_sum = 6'({yr[7:4], 1'b0}) + 6'(yr[3:0]);   // 10 is 2 mod 4
    if (mon == 8'h02) begin
      return (mod_sum[1:0] == 2'b00) ? 8'h29 : 8'h28;
    end
    if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      return 8'h30;
    end
    return 8'h31;
  endfunction : month_last

  // Time field mask for a clock slot
  function automatic logic [7:0] time_mask(input logic [2:0] s);
    unique case (s)
      tkr_pkg::SLOT_CENT: return tkr_pkg::TM_CENT;
      tkr_pkg::SLOT_SEC:  return tkr_pkg::TM_SEC;
      tkr_pkg::SLOT_MIN:  return tkr_pkg::TM_MIN;
      tkr_pkg::SLOT_HOUR: return tkr_pkg::TM_HOUR;
      tkr_pkg::SLOT_WDAY: return tkr_pkg::TM_WDAY;
      tkr_pkg::SLOT_DATE: return tkr_pkg::TM_DATE;
      tkr_pkg::SLOT_MON:  return tkr_pkg::TM_MON;
      tkr_pkg::SLOT_YEAR: return tkr_pkg::TM_YEAR;
    endcase
  endfunction : time_mask

  // Control bit mask for a clock slot
  function automatic logic [7:0] ctrl_mask(input logic [2:0] s);
    if (s == tkr_pkg::SLOT_CENT) begin
      return tkr_pkg::CM_CENT;
    end
    if (s == tkr_pkg::SLOT_SEC) begin
      return tkr_pkg::CM_SEC;
    end
    if (s == tkr_pkg::SLOT_WDAY) begin
      return tkr_pkg::CM_WDAY;
    end
    return 8'h00;
  endfunction : ctrl_mask

  // Storage; clock-area bytes keep their unassigned bits here too
  logic [7:0]  mem [0:tkr_pkg::MEM_DEPTH-1];
  logic [7:0]  cnt [0:tkr_pkg::SLOT_COUNT-1];   // Running counters
  logic [7:0]  usr [0:tkr_pkg::SLOT_COUNT-1];   // Host-visible image
  logic [7:0]  nxt [0:tkr_pkg::SLOT_COUNT-1];   // Counters after one second

  // Control bits, never frozen
  logic                write_bit;      // Halts view for loading
  logic                read_bit;       // Freezes view for reading
  logic                write_bit_q;    // Delayed, to spot the clearing edge
  logic                stop_bit;       // Oscillator stopped
  logic                freq_test_bit;  // 512 Hz test mode
  logic                batt_armed;     // Backup source connected

  // Divider and test wave
  logic [31:0]         sec_div;        // Cycle count inside one second
  logic [31:0]         ft_div;         // Cycle count inside half test period
  logic                sq_wave;        // 512 Hz square wave

  // Port sequencer
  tkr_pkg::tkr_state_t state;
  tkr_pkg::tkr_state_t next_state;
  logic [18:0]         wr_addr;        // Captured write address
  logic [7:0]          wr_data;        // Data from last active write cycle

  // Bus decode
  wire         sel        = ~host_bus.cs_n;
  wire         wr_req     = sel & ~host_bus.we_n;                   // R5
  wire         rd_req     = sel & host_bus.we_n;                    // R2
  wire         rd_drive   = rd_req & ~host_bus.oe_n & ~power_fail_level;  // R4 R7 R8
  wire         commit     = (state == tkr_pkg::TKR_END) & ~power_fail_level;  // R8
  wire         in_slots_r = (host_bus.addr[18:3] == tkr_pkg::SLOT_BASE_HI);
  wire [2:0]   slot_r     = host_bus.addr[2:0];
  wire         in_slots_w = (wr_addr[18:3] == tkr_pkg::SLOT_BASE_HI);
  wire [2:0]   slot_w     = wr_addr[2:0];
  wire         freeze     = write_bit | read_bit | write_bit_q;    // R14 R15
  wire         load_cnt   = write_bit_q & ~write_bit;               // R15

  // Clock alive only with oscillator on and an energy source present
  wire         osc_run    = ~stop_bit & (~switchover_level | batt_armed);  // R10 R12 R16
  wire         sec_tick   = osc_run & (sec_div == SEC_CYCLES_P - 1);

  // Read view of clock slot: time image plus live control bits
  wire [7:0]   ctrl_view  = (slot_r == tkr_pkg::SLOT_CENT) ? {write_bit, read_bit, 6'h00} :
                            (slot_r == tkr_pkg::SLOT_SEC)  ? {stop_bit, 7'h00} :
                            (slot_r == tkr_pkg::SLOT_WDAY) ? {battery_ok, freq_test_bit, 6'h00} :
                            8'h00;                                  // R13
  wire         ft_active  = freq_test_bit & ~stop_bit & (slot_r == tkr_pkg::SLOT_SEC);  // R17
  wire [7:0]   time_view  = ft_active ? {usr[slot_r][7:1], sq_wave} : usr[slot_r];  // R17
  wire [7:0]   ded_mask   = time_mask(slot_r) | ctrl_mask(slot_r);
  wire [7:0]   slot_byte  = (mem[host_bus.addr] & ~ded_mask) | time_view | ctrl_view;  // R1
  wire [7:0]   rd_byte    = in_slots_r ? slot_byte : mem[host_bus.addr];

  // One-second cascade of the BCD counters
  always_comb begin
    logic [8:0] s_r;
    logic [8:0] m_r;
    logic [8:0] h_r;
    logic [8:0] w_r;
    logic [8:0] d_r;
    logic [8:0] mo_r;
    logic [8:0] y_r;
    logic [8:0] c_r;
    s_r  = bcd_inc(cnt[tkr_pkg::SLOT_SEC], tkr_pkg::MAX_SEC, tkr_pkg::BCD_ZERO);  // R18
    m_r  = bcd_inc(cnt[tkr_pkg::SLOT_MIN], tkr_pkg::MAX_MIN, tkr_pkg::BCD_ZERO);
    h_r  = bcd_inc(cnt[tkr_pkg::SLOT_HOUR], tkr_pkg::MAX_HOUR, tkr_pkg::BCD_ZERO);
    w_r  = bcd_inc(cnt[tkr_pkg::SLOT_WDAY], tkr_pkg::MAX_WDAY, tkr_pkg::BCD_ONE);
    d_r  = bcd_inc(cnt[tkr_pkg::SLOT_DATE],
                   month_last(cnt[tkr_pkg::SLOT_MON], cnt[tkr_pkg::SLOT_YEAR]),
                   tkr_pkg::BCD_ONE);                                           // R18
    mo_r = bcd_inc(cnt[tkr_pkg::SLOT_MON], tkr_pkg::MAX_MON, tkr_pkg::BCD_ONE);
    y_r  = bcd_inc(cnt[tkr_pkg::SLOT_YEAR], tkr_pkg::MAX_YEAR, tkr_pkg::BCD_ZERO);
    c_r  = bcd_inc(cnt[tkr_pkg::SLOT_CENT], tkr_pkg::MAX_CENT, tkr_pkg::BCD_ZERO);
    for (int i = 0; i < tkr_pkg::SLOT_COUNT; i++) begin
      nxt[i] = cnt[i];
    end
    // Each field moves only when every lower field other than weekday wraps
    nxt[tkr_pkg::SLOT_SEC] = s_r[7:0];
    if (s_r[8]) begin
      nxt[tkr_pkg::SLOT_MIN] = m_r[7:0];
      if (m_r[8]) begin
        nxt[tkr_pkg::SLOT_HOUR] = h_r[7:0];
        if (h_r[8]) begin
          nxt[tkr_pkg::SLOT_WDAY] = w_r[7:0];
          nxt[tkr_pkg::SLOT_DATE] = d_r[7:0];
          if (d_r[8]) begin
            nxt[tkr_pkg::SLOT_MON] = mo_r[7:0];
            if (mo_r[8]) begin
              nxt[tkr_pkg::SLOT_YEAR] = y_r[7:0];
              if (y_r[8]) begin
                nxt[tkr_pkg::SLOT_CENT] = c_r[7:0];
              end
            end
          end
        end
      end
    end
  end

  // Port sequencer next state
  always_comb begin
    next_state = state;
    if (power_fail_level) begin
      next_state = tkr_pkg::TKR_IDLE;                               // R8
    end else begin
      unique case (state)
        tkr_pkg::TKR_WRITE: next_state = wr_req ? tkr_pkg::TKR_WRITE : tkr_pkg::TKR_END;
        tkr_pkg::TKR_IDLE,
        tkr_pkg::TKR_READ,
        tkr_pkg::TKR_END: begin
          // A write takes over whichever strobe arrived later
          next_state = wr_req ? tkr_pkg::TKR_WRITE :               // R5
                       rd_req ? tkr_pkg::TKR_READ : tkr_pkg::TKR_IDLE;
        end
      endcase
    end
  end

  // Sequencer register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= tkr_pkg::TKR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture address and data on every active write cycle; the last one counts
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_addr <= 19'h00000;
      wr_data <= 8'h00;
    end else if (next_state == tkr_pkg::TKR_WRITE) begin
      wr_addr <= host_bus.addr;                                     // R6
      wr_data <= host_bus.data;
    end
  end

  // Byte store; no reset, contents survive any power state
  always_ff @(posedge clk_sys) begin
    if (commit) begin
      mem[wr_addr] <= wr_data;                                      // R1 R10
    end
  end

  // Registered read data and pin drive
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      data_out  <= 8'h00;
      data_oe_n <= 1'b1;
    end else begin
      data_out  <= rd_byte;                                         // R3
      data_oe_n <= ~rd_drive;                                       // R4 R7
    end
  end

  // Open-drain reset: pull low only, released to the pull-up otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_out  <= 1'b0;
      rst_oe_n <= 1'b1;
    end else begin
      rst_out  <= 1'b0;                                             // R11
      rst_oe_n <= ~power_fail_level;                                // R9
    end
  end

  // Backup source stays off from shipment until supply first comes good
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      batt_armed <= 1'b0;
    end else if (!power_fail_level) begin
      batt_armed <= 1'b1;                                           // R12
    end
  end

  // Control bits from host writes; battery flag has no storage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      write_bit     <= 1'b0;
      read_bit      <= 1'b0;
      stop_bit      <= 1'b0;
      freq_test_bit <= 1'b0;
      write_bit_q   <= 1'b0;
    end else begin
      write_bit_q <= write_bit;
      if (commit && in_slots_w) begin
        if (slot_w == tkr_pkg::SLOT_CENT) begin
          write_bit <= wr_data[tkr_pkg::BIT_WRITE];                 // R15
          read_bit  <= wr_data[tkr_pkg::BIT_READ];                  // R14
        end
        if (slot_w == tkr_pkg::SLOT_SEC) begin
          stop_bit <= wr_data[tkr_pkg::BIT_STOP];                   // R16
        end
        if (slot_w == tkr_pkg::SLOT_WDAY) begin
          freq_test_bit <= wr_data[tkr_pkg::BIT_FTEST];             // R13 R17
        end
      end
    end
  end

  // Second divider; held at zero while stopped so a restart gives a full second
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sec_div <= 32'h00000000;
    end else if (!osc_run || sec_tick) begin
      sec_div <= 32'h00000000;                                      // R16
    end else begin
      sec_div <= sec_div + 32'h00000001;
    end
  end

  // Test square wave runs only with the oscillator
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ft_div  <= 32'h00000000;
      sq_wave <= 1'b0;
    end else if (!osc_run) begin
      ft_div <= 32'h00000000;
    end else if (ft_div == FT_HALF_P - 1) begin
      ft_div  <= 32'h00000000;
      sq_wave <= ~sq_wave;                                          // R17
    end else begin
      ft_div <= ft_div + 32'h00000001;
    end
  end

  // Running counters: load from image when write bit clears, else count
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cnt[tkr_pkg::SLOT_CENT] <= tkr_pkg::RST_CENT;
      cnt[tkr_pkg::SLOT_SEC]  <= tkr_pkg::RST_TIME;
      cnt[tkr_pkg::SLOT_MIN]  <= tkr_pkg::RST_TIME;
      cnt[tkr_pkg::SLOT_HOUR] <= tkr_pkg::RST_TIME;
      cnt[tkr_pkg::SLOT_WDAY] <= tkr_pkg::RST_WDAY;
      cnt[tkr_pkg::SLOT_DATE] <= tkr_pkg::RST_DATE;
      cnt[tkr_pkg::SLOT_MON]  <= tkr_pkg::RST_MON;
      cnt[tkr_pkg::SLOT_YEAR] <= tkr_pkg::RST_YEAR;
    end else if (load_cnt) begin
      cnt <= usr;                                                   // R15
    end else if (sec_tick) begin
      cnt <= nxt;                                                   // R10 R18
    end
  end

  // Host image: writes land here while frozen; tracks counters otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      usr[tkr_pkg::SLOT_CENT] <= tkr_pkg::RST_CENT;
      usr[tkr_pkg::SLOT_SEC]  <= tkr_pkg::RST_TIME;
      usr[tkr_pkg::SLOT_MIN]  <= tkr_pkg::RST_TIME;
      usr[tkr_pkg::SLOT_HOUR] <= tkr_pkg::RST_TIME;
      usr[tkr_pkg::SLOT_WDAY] <= tkr_pkg::RST_WDAY;
      usr[tkr_pkg::SLOT_DATE] <= tkr_pkg::RST_DATE;
      usr[tkr_pkg::SLOT_MON]  <= tkr_pkg::RST_MON;
      usr[tkr_pkg::SLOT_YEAR] <= tkr_pkg::RST_YEAR;
    end else if (commit && in_slots_w && freeze) begin
      usr[slot_w] <= wr_data & time_mask(slot_w);                  // R15
    end else if (!freeze) begin
      usr <= cnt;                                                   // R14
    end
  end

endmodule : tkr_port

// *** testbench/tkr_port_asserts.sv ***
/* Pin checker for tkr_port: drive, reset pin and read relations.
   Assumes one clk_sys domain; bound to every tkr_port below. */
`timescale 1ns/10ps
module tkr_port_asserts (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire tkr_pkg::tkr_bus_t host_bus,
  input wire logic              power_fail_level,
  input wire logic              switchover_level,
  input wire logic              battery_ok,
  input wire logic [7:0]        data_out,
  input wire logic              data_oe_n,
  input wire logic              rst_out,
  input wire logic              rst_oe_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Read request with supply good
  wire rd_req = !host_bus.cs_n && !host_bus.oe_n && host_bus.we_n && !power_fail_level;
  // Plain storage read, clock slots excluded since they tick
  sequence s_ram_rd;
    rd_req && (host_bus.addr[18:3] != tkr_pkg::SLOT_BASE_HI);
  endsequence
  property p_read_drive; rd_req |=> !data_oe_n; endproperty
  a_read_drive: assert property (p_read_drive) else $error("no drive on read");
  property p_no_drive; (host_bus.cs_n || host_bus.oe_n) |=> data_oe_n; endproperty
  a_no_drive: assert property (p_no_drive) else $error("drive while idle");
  property p_write_release; !host_bus.we_n |=> data_oe_n; endproperty
  a_write_release: assert property (p_write_release) else $error("drive in write");
  property p_pf_block; power_fail_level |=> data_oe_n; endproperty
  a_pf_block: assert property (p_pf_block) else $error("drive in power fail");
  property p_rst_follow; 1'b1 |=> rst_oe_n == !$past(power_fail_level); endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("reset pin wrong");
  property p_open_drain; rst_out == 1'b0; endproperty
  a_open_drain: assert property (p_open_drain) else $error("reset pin driven high");
  property p_ram_hold;
    (s_ram_rd ##1 (s_ram_rd and $stable(host_bus.addr))) |=> $stable(data_out);
  endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("read data moved");
  property p_batt_flag;
    (rd_req && host_bus.addr == tkr_pkg::OFS_WEEKDAY) |=> data_out[7] == $past(battery_ok);
  endproperty
  a_batt_flag: assert property (p_batt_flag) else $error("battery flag wrong");
  // Main scenarios reached
  c_read: cover property (rd_req ##1 !data_oe_n);
  c_write: cover property ((!host_bus.cs_n && !host_bus.we_n) ##1 host_bus.we_n);
  c_fail: cover property (power_fail_level ##1 !rst_oe_n);
endmodule : tkr_port_asserts

bind tkr_port tkr_port_asserts u_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .host_bus(host_bus),
  .power_fail_level(power_fail_level), .switchover_level(switchover_level),
  .battery_ok(battery_ok), .data_out(data_out), .data_oe_n(data_oe_n),
  .rst_out(rst_out), .rst_oe_n(rst_oe_n)
);

// *** testbench/tkr_host_model.sv ***
/* Host bus master model: strobes, address and the resolved data pins.
   Assumes the bench calls rd and wr one at a time. */
`timescale 1ns/10ps
module tkr_host_model (
  input  wire logic        clk_sys,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  output tkr_pkg::tkr_bus_t host_bus
);
  logic [2:0]  strb   = 3'h7;      // cs_n, oe_n, we_n
  logic [18:0] addr   = 19'h00000; // Held through each access
  logic [7:0]  drv    = 8'h00;     // Write data
  logic        drv_en = 1'b0;      // Host drives pins
  logic [7:0]  prev   = 8'h00;     // Last pin value
  // No pull on data: released pins wander so stale data cannot pass
  wire  [7:0]  pins = drv_en ? drv : (!data_oe_n ? data_out : ~prev);
  assign host_bus = {strb, addr, pins};
  // Track the wire for the wander pattern
  always_ff @(posedge clk_sys) prev <= pins;
  // Two read cycles; sample the pins after the second edge
  task automatic rd(input logic [18:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_sys) #1;
    strb = 3'b001;
    addr = a;
    @(posedge clk_sys);
    @(posedge clk_sys) #1;
    d = pins;
    oe = data_oe_n;
    strb = 3'b111;
  endtask : rd
  // Read mode first so the strobe must release the pins, then end cycle
  task automatic wr(input logic [18:0] a, input logic [7:0] v);
    @(posedge clk_sys) #1;
    strb = 3'b001;
    addr = a;
    @(posedge clk_sys) #1;
    strb = 3'b000;
    drv = v;
    drv_en = 1'b1;
    @(posedge clk_sys) #1;
    strb = 3'b111;
    drv_en = 1'b0;
    @(posedge clk_sys);
  endtask : wr
endmodule : tkr_host_model

// *** testbench/tkr_port_test.sv ***
/* Self-checking bench for tkr_port through the host model.
   Assumes a 20-cycle second and a 4-cycle test half period. */
`timescale 1ns/10ps
module tkr_port_test;
  logic              clk_sys = 1'b0;
  logic              reset_n = 1'b0;
  logic              power_fail_level = 1'b0;
  logic              switchover_level = 1'b0;
  logic              battery_ok = 1'b1;
  tkr_pkg::tkr_bus_t host_bus;
  logic [7:0]        data_out;
  logic              data_oe_n;
  logic              rst_out;
  logic              rst_oe_n;
  logic [7:0]        got;        // Pins seen by host
  logic              got_oe;     // Drive flag seen
  logic [7:0]        got_prev;   // Earlier pins, for the toggle check
  int                failures = 0;
  int                n_compared = 0;
  int                cycles = 0;
  tkr_port #(.SEC_CYCLES_P(20), .FT_HALF_P(4)) uut (
    .clk_sys(clk_sys), .reset_n(reset_n), .host_bus(host_bus),
    .power_fail_level(power_fail_level), .switchover_level(switchover_level),
    .battery_ok(battery_ok), .data_out(data_out), .data_oe_n(data_oe_n),
    .rst_out(rst_out), .rst_oe_n(rst_oe_n)
  );
  tkr_host_model host (
    .clk_sys(clk_sys), .data_out(data_out), .data_oe_n(data_oe_n), .host_bus(host_bus)
  );
  // 100 MHz clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the run of about 1600 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Read that must be driven, then the byte
  task automatic rchk(input logic [18:0] a, input logic [7:0] e);
    host.rd(a, got, got_oe);
    chk({7'h00, got_oe}, 8'h00);
    chk(got, e);
  endtask : rchk
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    @(posedge clk_sys) #1;
    chk({7'h00, rst_oe_n}, 8'h01);
    host.wr(19'h00010, 8'h11);
    host.wr(19'h00011, 8'h22);
    rchk(19'h00010, 8'h11);
    rchk(19'h00011, 8'h22);
    host.wr(tkr_pkg::OFS_MONTH, 8'he0);
    rchk(tkr_pkg::OFS_MONTH, 8'he1);
    host.wr(tkr_pkg::OFS_WEEKDAY, 8'h38);
    rchk(tkr_pkg::OFS_WEEKDAY, 8'hb9);
    battery_ok = 1'b0;
    rchk(tkr_pkg::OFS_WEEKDAY, 8'h39);
    battery_ok = 1'b1;
    // Load a stopped time, then let it stand
    host.wr(tkr_pkg::OFS_CENTURY, 8'ha0);
    host.wr(tkr_pkg::OFS_SECONDS, 8'hb0);
    host.wr(tkr_pkg::OFS_MINUTES, 8'h45);
    host.wr(tkr_pkg::OFS_CENTURY, 8'h20);
    repeat (60) @(posedge clk_sys);
    rchk(tkr_pkg::OFS_SECONDS, 8'hb0);
    rchk(tkr_pkg::OFS_MINUTES, 8'h45);
    // Seconds at 59 roll the minute within one second
    host.wr(tkr_pkg::OFS_CENTURY, 8'ha0);
    host.wr(tkr_pkg::OFS_SECONDS, 8'h59);
    host.wr(tkr_pkg::OFS_CENTURY, 8'h20);
    repeat (30) @(posedge clk_sys);
    rchk(tkr_pkg::OFS_MINUTES, 8'h46);
    // Frozen view across a minute boundary, then reload
    host.wr(tkr_pkg::OFS_CENTURY, 8'h60);
    repeat (1300) @(posedge clk_sys);
    rchk(tkr_pkg::OFS_MINUTES, 8'h46);
    host.wr(tkr_pkg::OFS_CENTURY, 8'h20);
    rchk(tkr_pkg::OFS_MINUTES, 8'h47);
    // Test wave: seconds bit 0 flips between reads one half period apart
    host.wr(tkr_pkg::OFS_WEEKDAY, 8'h40);
    host.rd(tkr_pkg::OFS_SECONDS, got, got_oe);
    got_prev = got;
    @(posedge clk_sys);
    host.rd(tkr_pkg::OFS_SECONDS, got, got_oe);
    chk({7'h00, got[0]}, {7'h00, ~got_prev[0]});
    // Power fail: no drive, write dropped, reset pin low
    power_fail_level = 1'b1;
    host.wr(19'h00010, 8'h5a);
    host.rd(19'h00010, got, got_oe);
    chk({7'h00, got_oe}, 8'h01);
    chk({7'h00, rst_oe_n}, 8'h00);
    chk({7'h00, rst_out}, 8'h00);
    power_fail_level = 1'b0;
    rchk(19'h00010, 8'h11);
    chk({7'h00, rst_oe_n}, 8'h01);
    // Fresh part on backup: clock idles until supply first comes good
    power_fail_level = 1'b1;
    switchover_level = 1'b1;
    reset_n = 1'b0;
    repeat (3) @(posedge clk_sys) #1;
    reset_n = 1'b1;
    repeat (60) @(posedge clk_sys) #1;
    power_fail_level = 1'b0;
    switchover_level = 1'b0;
    rchk(tkr_pkg::OFS_SECONDS, 8'h00);
    // Armed now, so the calendar keeps counting on backup
    power_fail_level = 1'b1;
    switchover_level = 1'b1;
    repeat (45) @(posedge clk_sys) #1;
    power_fail_level = 1'b0;
    switchover_level = 1'b0;
    rchk(tkr_pkg::OFS_SECONDS, 8'h02);
    tally_and_finish();
  end
endmodule : tkr_port_test
